/* File: hw/twep_core.sv */
// Contract
// RULE1 - Width select high: 16-bit words, else 8
// RULE2 - Serial input sampled on serial clock rise
// RULE3 - Output released except read or status
// RULE4 - Status low while programming, high after
// RULE5 - Chip select fall releases the output
// RULE6 - Start bit: select and input high
// RULE7 - Nothing happens before a start bit
// RULE8 - Standby ends when chip select rises
// RULE9 - Execute only after all bits arrive
// RULE10 - After last bit, ignore until start
// RULE11 - Programming disabled after power-up
// RULE12 - Read: dummy zero, then word MSB first
// RULE13 - Read bits change on clock rise
// RULE14 - Select held high: sequential words follow
// RULE15 - Opcode and sub-opcode decoding
// RULE16 - Address width per organisation
// RULE17 - Master supplies the full clock count
// RULE18 - Program cycle time limits per operation
// RULE19 - Tied pins contend on dummy zero
// RULE20 - Select fall after last bit programs
// RULE21 - Enable persists until disable; read free
// RULE22 - Select low resets control, not programming
// RULE23 - Erase to ones; writes auto-erase
// RULE24 - Disabled state discards programming commands
`timescale 1ns/1ps

module twep_core #(
	parameter int PROG_CYC = twep_pkg::PROG_CYC,
	parameter int ERASE_ENTIRE_ARRAY_CMD_CYC = twep_pkg::ERASE_ENTIRE_ARRAY_CMD_CYC,
	parameter int FILL_ENTIRE_ARRAY_CMD_CYC = twep_pkg::FILL_ENTIRE_ARRAY_CMD_CYC
) (
	input  wire logic core_clk,
	input  wire logic rstn,
	input  wire logic chip_sel,
	input  wire logic ser_clk,
	input  wire logic serial_in,
	input  wire logic word_width_select,
	output logic      serial_out,
	output logic      serial_out_oe
);

	// ****************************************
	// State
	// ****************************************
	twep_pkg::twep_state_type s;
	twep_pkg::twep_state_type n;

	logic       clk_rise;
	logic       cs_now;
	logic       cs_fall;
	logic       si_now;
	logic       wide;
	logic [4:0] aw;
	logic [4:0] dw;
	logic [1:0] sub;
	logic       addr_last;

	// Edges use the second and third sync stages, levels only the second
	assign clk_rise  = s.clk_sync[1] & ~s.clk_sync[2];
	assign cs_now    = s.cs_sync[1];
	assign cs_fall   = s.cs_sync[2] & ~s.cs_sync[1];
	assign si_now    = s.si_sync[1];
	assign wide      = s.org_sync[1];
	assign aw        = wide ? twep_pkg::AW_WIDE : twep_pkg::AW_NARROW; // RULE16
	assign dw        = wide ? twep_pkg::DW_WIDE : twep_pkg::DW_NARROW; // RULE1
	assign sub       = wide ? s.addr[7:6] : s.addr[8:7];
	assign addr_last = (s.fsm == twep_pkg::ST_ADDR) && clk_rise &&
		(s.cnt == aw - 5'h01);

	// ****************************************
	// Word fetch, MSB at bit 15
	// ****************************************
	function automatic logic [15:0] rd_word(
		input twep_pkg::twep_state_type st,
		input logic [8:0]               a,
		input logic                     w
	);
		logic [15:0] r;
		if (w) begin
			r = {st.mem[{a[7:0], 1'b0}], st.mem[{a[7:0], 1'b1}]};
		end else begin
			r = {st.mem[a], 8'h00};
		end
		return r;
	endfunction

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic [8:0]  nxt_a;
		logic [15:0] nxt_w;
		nxt_a = wide ? {1'b0, s.addr[7:0] + 8'h01} : s.addr + 9'h001;
		nxt_w = rd_word(s, nxt_a, wide);
		n = s;
		n.clk_sync = {s.clk_sync[1:0], ser_clk};
		n.cs_sync  = {s.cs_sync[1:0], chip_sel};
		n.si_sync  = {s.si_sync[0], serial_in};
		n.org_sync = {s.org_sync[0], word_width_select};

		// Self-timed cycle runs regardless of select
		if (s.busy) begin // RULE18 RULE22
			if (s.tmr == '0) begin
				n.busy = 1'b0;
			end else begin
				n.tmr = s.tmr - twep_pkg::TMR_W'(1);
			end
		end

		// Status shows only in idle with select high
		n.doe  = cs_now && s.show && (s.fsm == twep_pkg::ST_IDLE); // RULE3 RULE5
		n.dout = ~s.busy; // RULE4

		if (!cs_now) begin
			n.fsm = twep_pkg::ST_IDLE; // RULE22
			n.cnt = '0;
			if (cs_fall && !s.busy) begin
				n.show = 1'b0;
			end
			// Select fall after the last bit programs
			if (cs_fall && (s.fsm == twep_pkg::ST_HOLD) && s.prog_en) begin // RULE20 RULE24
				n.busy = 1'b1;
				n.show = 1'b1;
				if (s.opc == twep_pkg::OP_ERASE) begin // RULE23
					n.tmr = twep_pkg::TMR_W'(PROG_CYC - 1);
					if (wide) begin
						n.mem[{s.addr[7:0], 1'b0}] = twep_pkg::ERASED;
						n.mem[{s.addr[7:0], 1'b1}] = twep_pkg::ERASED;
					end else begin
						n.mem[s.addr] = twep_pkg::ERASED;
					end
				end else if (s.opc == twep_pkg::OP_WRITE) begin // RULE23
					n.tmr = twep_pkg::TMR_W'(PROG_CYC - 1);
					if (wide) begin
						n.mem[{s.addr[7:0], 1'b0}] = s.sh[15:8];
						n.mem[{s.addr[7:0], 1'b1}] = s.sh[7:0];
					end else begin
						n.mem[s.addr] = s.sh[7:0];
					end
				end else if (sub == twep_pkg::SUB_ERASE_ENTIRE_ARRAY_CMD) begin
					n.tmr = twep_pkg::TMR_W'(ERASE_ENTIRE_ARRAY_CMD_CYC - 1);
					for (int i = 0; i < twep_pkg::MEM_BYTES; i++) begin
						n.mem[i] = twep_pkg::ERASED;
					end
				end else begin
					// Fill overwrites every byte, erase implied
					n.tmr = twep_pkg::TMR_W'(FILL_ENTIRE_ARRAY_CMD_CYC - 1);
					for (int i = 0; i < twep_pkg::MEM_BYTES; i++) begin
						n.mem[i] = (wide && (i % 2 == 0)) ? s.sh[15:8] : s.sh[7:0];
					end
				end
			end
		end else begin
			case (s.fsm)
				twep_pkg::ST_IDLE: begin
					// No start while busy: status owns the pin
					if (clk_rise && si_now && !s.busy) begin // RULE6 RULE7 RULE8
						n.fsm  = twep_pkg::ST_OPC;
						n.cnt  = '0;
						n.addr = '0;
						n.show = 1'b0;
						// Ready level must not linger into the opcode
						n.doe  = 1'b0; // RULE3
					end
				end
				twep_pkg::ST_OPC: begin
					if (clk_rise) begin // RULE2
						n.opc = {s.opc[0], si_now};
						n.cnt = s.cnt + 5'h01;
						if (s.cnt == twep_pkg::OPC_BITS - 5'h01) begin
							n.fsm = twep_pkg::ST_ADDR;
							n.cnt = '0;
						end
					end
				end
				twep_pkg::ST_ADDR: begin
					if (clk_rise) begin // RULE2
						n.addr = {s.addr[7:0], si_now};
						n.cnt  = s.cnt + 5'h01;
					end
					if (addr_last) begin // RULE9 RULE15
						n.cnt = '0;
						case (s.opc)
							twep_pkg::OP_READ: begin
								n.fsm  = twep_pkg::ST_READ;
								n.sh   = rd_word(s, {s.addr[7:0], si_now}, wide);
								n.doe  = 1'b1;
								n.dout = 1'b0; // RULE12 RULE19
							end
							twep_pkg::OP_WRITE: begin
								n.fsm = twep_pkg::ST_DATA;
							end
							twep_pkg::OP_ERASE: begin
								n.fsm = twep_pkg::ST_HOLD;
							end
							default: begin
								// Last address bit not yet shifted into addr
								case (wide ? s.addr[6:5] : s.addr[7:6])
									twep_pkg::SUB_EN: begin
										n.prog_en = 1'b1; // RULE21
										n.fsm     = twep_pkg::ST_DONE;
									end
									twep_pkg::SUB_DIS: begin
										n.prog_en = 1'b0; // RULE21
										n.fsm     = twep_pkg::ST_DONE;
									end
									twep_pkg::SUB_FILL: begin
										n.fsm = twep_pkg::ST_DATA;
									end
									default: begin
										n.fsm = twep_pkg::ST_HOLD;
									end
								endcase
							end
						endcase
					end
				end
				twep_pkg::ST_DATA: begin
					if (clk_rise) begin // RULE2
						n.sh  = {s.sh[14:0], si_now};
						n.cnt = s.cnt + 5'h01;
						if (s.cnt == dw - 5'h01) begin // RULE9
							n.fsm = twep_pkg::ST_HOLD;
						end
					end
				end
				twep_pkg::ST_READ: begin
					n.doe  = 1'b1;
					n.dout = s.dout;
					if (clk_rise) begin // RULE13
						if (s.cnt == dw) begin
							// Roll into next word, no dummy bit
							n.addr = nxt_a; // RULE14
							n.sh   = nxt_w << 1;
							n.dout = nxt_w[15];
							n.cnt  = 5'h01;
						end else begin
							n.dout = s.sh[15]; // RULE12
							n.sh   = s.sh << 1;
							n.cnt  = s.cnt + 5'h01;
						end
					end
				end
				twep_pkg::ST_HOLD: begin
					// Extra clock before select falls cancels
					if (clk_rise) begin // RULE20
						n.fsm = twep_pkg::ST_DONE;
					end
				end
				twep_pkg::ST_DONE: begin
					n.fsm = twep_pkg::ST_DONE; // RULE10
				end
				default: begin
					n.fsm = twep_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s          <= '0;
			s.fsm      <= twep_pkg::ST_IDLE;
			s.prog_en  <= 1'b0; // RULE11
			s.mem      <= {twep_pkg::MEM_BYTES{twep_pkg::ERASED}};
		end else begin
			s <= n;
		end
	end

	assign serial_out    = s.dout;
	assign serial_out_oe = s.doe;

	// ****************************************
	// Checks
	// ****************************************
	chk_cs_fall_release: assert property ( // RULE5
		@(posedge core_clk) disable iff (!rstn)
		cs_fall |=> !serial_out_oe
	) else $error("output not released on select fall");

	chk_no_start_idle: assert property ( // RULE7
		@(posedge core_clk) disable iff (!rstn)
		(s.fsm == twep_pkg::ST_IDLE) && !(clk_rise && si_now)
		|=> s.fsm == twep_pkg::ST_IDLE
	) else $error("left idle without start bit");

	chk_oe_cause: assert property ( // RULE3
		@(posedge core_clk) disable iff (!rstn)
		serial_out_oe |-> $past(cs_now) &&
		(s.fsm == twep_pkg::ST_READ || s.show)
	) else $error("output driven outside read or status");

	chk_status_busy: assert property ( // RULE4
		@(posedge core_clk) disable iff (!rstn)
		s.busy && s.show && cs_now && (s.fsm == twep_pkg::ST_IDLE)
		|=> serial_out_oe && !serial_out
	) else $error("busy status not low");

	chk_read_dummy: assert property ( // RULE12
		@(posedge core_clk) disable iff (!rstn)
		addr_last && cs_now && (s.opc == twep_pkg::OP_READ)
		|=> serial_out_oe && !serial_out ##0 s.fsm == twep_pkg::ST_READ
	) else $error("read dummy zero missing");

	chk_disabled_drop: assert property ( // RULE24
		@(posedge core_clk) disable iff (!rstn)
		cs_fall && (s.fsm == twep_pkg::ST_HOLD) && !s.prog_en && !s.busy
		|=> !s.busy && $stable(s.mem)
	) else $error("programming while disabled");

	chk_prog_start: assert property ( // RULE20
		@(posedge core_clk) disable iff (!rstn)
		cs_fall && (s.fsm == twep_pkg::ST_HOLD) && s.prog_en
		|=> s.busy && s.show
	) else $error("program cycle not started");

	chk_cs_low_reset: assert property ( // RULE22
		@(posedge core_clk) disable iff (!rstn)
		!cs_now |=> s.fsm == twep_pkg::ST_IDLE
	) else $error("control not reset with select low");

	chk_done_stays: assert property ( // RULE10
		@(posedge core_clk) disable iff (!rstn)
		(s.fsm == twep_pkg::ST_DONE) && cs_now |=> s.fsm == twep_pkg::ST_DONE
	) else $error("left done without select low");

	chk_prog_end: assert property ( // RULE18
		@(posedge core_clk) disable iff (!rstn)
		s.busy && (s.tmr == '0) |=> !s.busy
	) else $error("program cycle overran");

	chk_start_seen: assert property ( // RULE6
		@(posedge core_clk) disable iff (!rstn)
		cs_now && (s.fsm == twep_pkg::ST_IDLE) && clk_rise && si_now && !s.busy
		|=> s.fsm == twep_pkg::ST_OPC
	) else $error("start bit not taken");

	chk_read_steady: assert property ( // RULE13
		@(posedge core_clk) disable iff (!rstn)
		cs_now && (s.fsm == twep_pkg::ST_READ) && !clk_rise |=> $stable(serial_out)
	) else $error("read bit moved without clock rise");

	chk_done_quiet: assert property ( // RULE10
		@(posedge core_clk) disable iff (!rstn)
		(s.fsm == twep_pkg::ST_DONE) |=> !serial_out_oe
	) else $error("output driven after instruction end");

	chk_enable_kept: assert property ( // RULE21
		@(posedge core_clk) disable iff (!rstn)
		s.prog_en && !(addr_last && (s.opc == twep_pkg::OP_MISC)) |=> s.prog_en
	) else $error("programming enable lost");

endmodule // twep_core

/* File: hw/twep_pkg.sv */
package twep_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ     = 20_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int T_PROG_MS  = 10;
	localparam int T_ERASE_ENTIRE_ARRAY_CMD_MS  = 15;
	localparam int T_FILL_ENTIRE_ARRAY_CMD_MS  = 30;
	localparam int PROG_CYC   = T_PROG_MS * CYC_PER_MS;
	localparam int ERASE_ENTIRE_ARRAY_CMD_CYC   = T_ERASE_ENTIRE_ARRAY_CMD_MS * CYC_PER_MS;
	localparam int FILL_ENTIRE_ARRAY_CMD_CYC   = T_FILL_ENTIRE_ARRAY_CMD_MS * CYC_PER_MS;
	localparam int TMR_W      = 20;

	// ****************************************
	// Geometry
	// ****************************************
	localparam int          MEM_BYTES = 512;
	localparam int          CNT_W     = 5;
	localparam logic [4:0]  AW_WIDE   = 5'h08;
	localparam logic [4:0]  AW_NARROW = 5'h09;
	localparam logic [4:0]  DW_WIDE   = 5'h10;
	localparam logic [4:0]  DW_NARROW = 5'h08;
	localparam logic [4:0]  OPC_BITS  = 5'h02;
	localparam logic [7:0]  ERASED    = 8'hFF;

	// ****************************************
	// Instruction codes
	// ****************************************
	localparam logic [1:0] OP_MISC  = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ  = 2'h2;
	localparam logic [1:0] OP_ERASE = 2'h3;
	localparam logic [1:0] SUB_DIS  = 2'h0;
	localparam logic [1:0] SUB_FILL = 2'h1;
	localparam logic [1:0] SUB_ERASE_ENTIRE_ARRAY_CMD = 2'h2;
	localparam logic [1:0] SUB_EN   = 2'h3;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_OPC,
		ST_ADDR,
		ST_DATA,
		ST_READ,
		ST_HOLD,
		ST_DONE
	} twep_fsm_type;

	typedef struct packed {
		logic [2:0]                  clk_sync;
		logic [2:0]                  cs_sync;
		logic [1:0]                  si_sync;
		logic [1:0]                  org_sync;
		twep_fsm_type                fsm;
		logic [CNT_W-1:0]            cnt;
		logic [1:0]                  opc;
		logic [8:0]                  addr;
		logic [15:0]                 sh;
		logic                        prog_en;
		logic                        busy;
		logic                        show;
		logic [TMR_W-1:0]            tmr;
		logic                        dout;
		logic                        doe;
		logic [MEM_BYTES-1:0][7:0]   mem;
	} twep_state_type;

endpackage

/* File: tb/three_wire_eeprom_port_bench.sv */
`timescale 1ns/1ps

module three_wire_eeprom_port_bench;
	localparam int LIMIT = 30000;
	logic        core_clk;
	logic        rstn;
	logic        word_width_select;
	wire         chip_sel;
	wire         ser_clk;
	wire         serial_in;
	wire         serial_out;
	wire         serial_out_oe;
	int          err_count;
	int          checks;
	int          cycles;
	logic [15:0] r;
	logic        d0;

	twep_core #(.PROG_CYC(50), .ERASE_ENTIRE_ARRAY_CMD_CYC(80), .FILL_ENTIRE_ARRAY_CMD_CYC(120)) dut (
		.core_clk(core_clk), .rstn(rstn), .chip_sel(chip_sel), .ser_clk(ser_clk),
		.serial_in(serial_in), .word_width_select(word_width_select),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe));

	twep_master m (
		.core_clk(core_clk), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
		.chip_sel(chip_sel), .ser_clk(ser_clk), .serial_in(serial_in));

	always #25 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			err_count++;
			tally_and_finish();
		end
	end

	// ****************
	// Checking and closing
	// ****************
	task automatic compare(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic cmd(input logic [1:0] opc, input logic [8:0] a, input logic [15:0] v,
		input int dn);
		m.frame(opc, a, word_width_select ? 8 : 9, d0);
		m.shift(v, dn, r);
	endtask

	task automatic rd(input logic [8:0] a, input logic [15:0] e0, input logic [15:0] e1);
		int dn;
		dn = word_width_select ? 16 : 8;
		cmd(twep_pkg::OP_READ, a, 16'h0000, 0);
		compare({15'h0000, d0}, 16'h0000);
		m.shift(16'h0000, dn, r);
		compare(r, e0);
		m.shift(16'h0000, dn, r);
		compare(r, e1);
		m.deselect();
		compare({15'h0000, serial_out_oe}, 16'h0000);
	endtask

	// Busy seen must end within 20 cycles below the full cycle count, never above it
	task automatic prog(input int cyc, input logic en);
		logic f;
		int   w;
		m.deselect();
		m.status(cyc + 40, f, w);
		compare({15'h0000, serial_out_oe}, {15'h0000, en});
		compare({15'h0000, f}, {15'h0000, !en});
		compare({15'h0000, m.dline}, 16'h0001);
		if (en)
			compare({15'h0000, w > cyc - 20 && w <= cyc}, 16'h0001);
		m.deselect();
		compare({15'h0000, serial_out_oe}, 16'h0000);
	endtask

	task automatic t_locked();
		cmd(twep_pkg::OP_WRITE, 9'h005, 16'h1234, 16);
		prog(50, 1'b0);
		rd(9'h005, 16'hFFFF, 16'hFFFF);
	endtask

	task automatic t_write();
		cmd(twep_pkg::OP_MISC, {1'b0, twep_pkg::SUB_EN, 6'h00}, 16'h0000, 0);
		m.deselect();
		cmd(twep_pkg::OP_WRITE, 9'h005, 16'hA55A, 16);
		prog(50, 1'b1);
		rd(9'h005, 16'hA55A, 16'hFFFF);
		word_width_select = 1'b0;
		rd(9'h00A, 16'h00A5, 16'h005A);
		cmd(twep_pkg::OP_WRITE, 9'h1FF, 16'h003C, 8);
		prog(50, 1'b1);
		rd(9'h1FF, 16'h003C, 16'h00FF);
		word_width_select = 1'b1;
	endtask

	task automatic t_bulk();
		cmd(twep_pkg::OP_ERASE, 9'h005, 16'h0000, 0);
		prog(50, 1'b1);
		rd(9'h005, 16'hFFFF, 16'hFFFF);
		cmd(twep_pkg::OP_MISC, {1'b0, twep_pkg::SUB_FILL, 6'h00}, 16'h0F0F, 16);
		prog(120, 1'b1);
		rd(9'h080, 16'h0F0F, 16'h0F0F);
		cmd(twep_pkg::OP_MISC, {1'b0, twep_pkg::SUB_ERASE_ENTIRE_ARRAY_CMD, 6'h00}, 16'h0000, 0);
		prog(80, 1'b1);
		rd(9'h080, 16'hFFFF, 16'hFFFF);
	endtask

	// Extra clock before deselect aborts; then lock and retry
	task automatic t_cancel();
		cmd(twep_pkg::OP_WRITE, 9'h003, 16'h1111, 16);
		m.bit_io(1'b0, d0);
		prog(50, 1'b0);
		rd(9'h003, 16'hFFFF, 16'hFFFF);
		cmd(twep_pkg::OP_MISC, {1'b0, twep_pkg::SUB_DIS, 6'h00}, 16'h0000, 0);
		m.deselect();
		cmd(twep_pkg::OP_WRITE, 9'h003, 16'h1111, 16);
		prog(50, 1'b0);
		rd(9'h003, 16'hFFFF, 16'hFFFF);
	endtask

	initial begin
		err_count = 0;
		checks = 0;
		cycles = 0;
		core_clk = 1'b0;
		rstn = 1'b0;
		word_width_select = 1'b1;
		repeat (4) @(negedge core_clk);
		rstn = 1'b1;
		repeat (6) @(negedge core_clk);
		t_locked();
		t_write();
		t_bulk();
		t_cancel();
		tally_and_finish();
	end
endmodule // three_wire_eeprom_port_bench

/* File: tb/twep_master.sv */
`timescale 1ns/1ps

module twep_master (
	input  wire logic core_clk,
	input  wire logic serial_out,
	input  wire logic serial_out_oe,
	output logic      chip_sel,
	output logic      ser_clk,
	output logic      serial_in
);
	// Pull-up on the data line; data in and out kept on separate wires
	wire dline = serial_out_oe ? serial_out : 1'b1;

	initial begin
		chip_sel = 1'b0;
		ser_clk = 1'b0;
		serial_in = 1'b0;
	end

	task automatic idle(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// ****************
	// Serial clock, five core cycles per phase
	// ****************
	task automatic bit_io(input logic b, output logic s);
		serial_in = b;
		idle(5);
		ser_clk = 1'b1;
		idle(5);
		ser_clk = 1'b0;
		s = dline;
	endtask

	task automatic shift(input logic [15:0] v, input int n, output logic [15:0] r);
		logic s;
		r = 16'h0000;
		for (int i = n - 1; i >= 0; i--) begin
			bit_io(v[i], s);
			r = {r[14:0], s};
		end
	endtask

	// Leading zeros must not count as a start
	task automatic frame(input logic [1:0] opc, input logic [8:0] a, input int aw,
		output logic d0);
		logic [15:0] r;
		chip_sel = 1'b1;
		idle(5);
		shift(16'h0000, 2, r);
		shift({13'h0000, 1'b1, opc}, 3, r);
		shift({7'h00, a}, aw, r);
		d0 = r[0];
	endtask

	// Serial input toggles once deselected so no stale level lingers
	task automatic deselect();
		chip_sel = 1'b0;
		serial_in = !serial_in;
		idle(8);
	endtask

	task automatic status(input int lim, output logic first, output int w);
		chip_sel = 1'b1;
		idle(6);
		first = dline;
		w = 0;
		while (dline !== 1'b1 && w < lim) begin
			idle(1);
			w++;
		end
	endtask
endmodule // twep_master
